// ---- verilog/lcsd_pkg.sv ----
// constants and register map for the linked cable status block
// Operation
// - A negative link pulse sets the polarity flag, seen at bit 12 of the status word and bit 4 of the 10Mb word.
// - The polarity flag only has meaning in 10Mb modes and is held clear at 100Mb.
// - The receiver inverts incoming data itself while the polarity flag is set.
// - During auto-negotiation with auto crossover on, swapped pairs are detected and MDIX is chosen, else MDI.
// - The resolved crossover state shows at bit 14 of the status word.
// - Frequency offset is reported only at 100Mb with a valid link, through the frequency readout register.
// - Both the long-term offset and the current frequency-control value are exposed.
// - The electrical cable length is produced only at 100Mb with a valid link.
// - The cable length is reported in meters in one register, read in a single access.
// - Length is slope times the digital equalizer coefficient plus offset, the pair chosen by the analog setting.
// - Each receiver decision carries one of three symbol levels and an error against the ideal level.
// - Error variance is summed over a 2, 4, 6 or 8 ms window chosen in the variance control register.
// - A variance is kept per symbol level and the three are added into one readable sum.
// - While enabled, a fresh sum is published at the end of every window.
// - Clearing the enable stops the variance computation.
`default_nettype none
package lcsd_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
  localparam int unsigned WIN_STEP_MS = 2;

  localparam logic [7:0] REG_PHY_STS = 8'h00;
  localparam logic [7:0] REG_TEN_SC = 8'h04;
  localparam logic [7:0] REG_FREQ = 8'h08;
  localparam logic [7:0] REG_LEN = 8'h0C;
  localparam logic [7:0] REG_VAR_CTRL = 8'h10;
  localparam logic [7:0] REG_VAR_DATA = 8'h14;
  localparam logic [7:0] REG_VAR_CNT = 8'h18;

  localparam int unsigned PHY_LINK_BIT = 0;
  localparam int unsigned PHY_SPD_BIT = 1;
  localparam int unsigned PHY_POL_BIT = 12;
  localparam int unsigned PHY_MDIX_BIT = 14;
  localparam int unsigned TEN_POL_BIT = 4;
  localparam int unsigned VC_EN_BIT = 0;
  localparam int unsigned VC_TSEL_LSB = 1;
  localparam int unsigned FREQ_CTL_LSB = 8;

  localparam int unsigned LVL_NUM = 3;
  localparam logic [1:0] LVL_CODE [LVL_NUM] = '{2'h3, 2'h0, 2'h1};
  localparam int unsigned ACC_W = 36;
  localparam int unsigned SUM_W = 38;
  localparam logic [31:0] VAR_SAT = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  localparam int unsigned AEQ_W = 3;
  localparam int unsigned SLOPE_FRAC = 4;
  localparam logic [7:0] LEN_MAX = 8'hFF;
  localparam logic [7:0] LEN_SLOPE [2**AEQ_W] = '{8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14, 8'h16};
  localparam logic [7:0] LEN_OFFSET [2**AEQ_W] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
endpackage
`default_nettype wire

// ---- verilog/lcsd_len_coef.sv ----
// slope and offset table for the cable length estimate, registered read
`default_nettype none
module lcsd_len_coef
  import lcsd_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [AEQ_W-1:0] sel_in,
  output logic      [7:0]       slope_out,
  output logic      [7:0]       offset_out
);
  typedef struct packed {
    logic [7:0] slope;
    logic [7:0] offset;
  } lcsd_coef_t;

  lcsd_coef_t s_q;
  lcsd_coef_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.slope = LEN_SLOPE[sel_in];
    s_d.offset = LEN_OFFSET[sel_in];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign slope_out = s_q.slope;
  assign offset_out = s_q.offset;
endmodule
`default_nettype wire

// ---- verilog/lcsd_top.sv ----
// linked cable status: polarity, crossover, frequency, length and variance
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`default_nettype none
module lcsd_top
  import lcsd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  input  wire logic              link_valid_in,
  input  wire logic              speed_100_in,
  input  wire logic              neg_link_pulse_in,
  input  wire logic              pos_link_pulse_in,
  input  wire logic              rx_data_in,
  output logic                   rx_data_out,
  input  wire logic              autoneg_active_in,
  input  wire logic              auto_mdix_en_in,
  input  wire logic              pair_swap_in,
  output logic                   mdix_out,
  input  wire logic [7:0]        freq_offset_in,
  input  wire logic [7:0]        freq_ctrl_in,
  input  wire logic [AEQ_W-1:0]  analog_equalizer_setting_in,
  input  wire logic [7:0]        digital_equalizer_coeff_in,
  input  wire logic              sym_valid_in,
  input  wire logic [1:0]        sym_level_in,
  input  wire logic signed [7:0] sym_err_in
);
  typedef logic [ACC_W-1:0] lcsd_acc_t;

  typedef struct packed {
    logic                        pol;
    logic                        rx;
    logic                        mdix;
    logic [7:0]                  foff;
    logic [7:0]                  fctl;
    logic [7:0]                  len;
    logic                        en;
    logic [1:0]                  tsel;
    logic [15:0]                 cyc;
    logic [3:0]                  ms;
    logic [LVL_NUM-1:0][ACC_W-1:0] acc;
    logic [31:0]                 var_data;
    logic [15:0]                 win_cnt;
    logic                        ack;
    logic [31:0]                 rdat;
  } lcsd_state_t;

  lcsd_state_t s_q;
  lcsd_state_t s_d;

  logic                          lnk100;
  logic [7:0]                    slope;
  logic [7:0]                    offset;
  logic [15:0]                   prod;
  logic [8:0]                    len_sum;
  logic [15:0]                   sq;
  logic [LVL_NUM-1:0]            hit;
  logic [LVL_NUM-1:0][ACC_W-1:0] acc_nx;
  logic [SUM_W-1:0]              sum3;
  logic [31:0]                   sum_sat;
  logic [3:0]                    win_ms;
  logic                          ms_tick;
  logic                          win_end;
  logic                          wb_req;

  // frequency and length only mean something on a live 100Mb link
  assign lnk100 = link_valid_in & speed_100_in;
  assign wb_req = wb_cyc_in & wb_stb_in;

  lcsd_len_coef u_coef (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .sel_in     (analog_equalizer_setting_in),
    .slope_out  (slope),
    .offset_out (offset)
  );

  // slope is fixed point, so the product drops its fraction bits
  assign prod = 16'(slope) * 16'(digital_equalizer_coeff_in);
  assign len_sum = 9'(prod >> SLOPE_FRAC) + 9'(offset);

  // squared error against the ideal level; an 8 bit error cannot overflow 16 bits
  assign sq = 16'(sym_err_in * sym_err_in);

  for (genvar g = 0; g < LVL_NUM; g++) begin : g_lvl
    assign hit[g] = sym_valid_in && (sym_level_in == LVL_CODE[g]);
    assign acc_nx[g] = s_q.acc[g] + (hit[g] ? lcsd_acc_t'(sq) : lcsd_acc_t'(0));
  end

  assign sum3 = SUM_W'(acc_nx[0]) + SUM_W'(acc_nx[1]) + SUM_W'(acc_nx[2]);
  // saturate rather than wrap so a noisy link never reads as a clean one
  assign sum_sat = (|sum3[SUM_W-1:32]) ? VAR_SAT : sum3[31:0];

  assign win_ms = 4'((32'(s_q.tsel) + 1) * WIN_STEP_MS);
  assign ms_tick = s_q.en && (s_q.cyc == 16'(MS_CYCLES - 1));
  assign win_end = ms_tick && (s_q.ms == win_ms - 4'h1);

  always_comb begin
    logic [31:0] rd;
    rd = WORD_ZERO;
    s_d = s_q;

    // polarity: set wins over the positive pulse clear on the same cycle, the 100Mb clear wins over both
    if (speed_100_in) begin
      s_d.pol = 1'b0;
    end else if (neg_link_pulse_in) begin
      s_d.pol = 1'b1;
    end else if (pos_link_pulse_in) begin
      s_d.pol = 1'b0;
    end
    s_d.rx = rx_data_in ^ s_q.pol;

    // crossover decided only while negotiating, held afterwards
    if (autoneg_active_in) begin
      s_d.mdix = auto_mdix_en_in & pair_swap_in;
    end

    if (lnk100) begin
      s_d.foff = freq_offset_in;
      s_d.fctl = freq_ctrl_in;
      s_d.len = len_sum[8] ? LEN_MAX : len_sum[7:0];
    end else begin
      s_d.foff = '0;
      s_d.fctl = '0;
      s_d.len = '0;
    end

    // variance window, millisecond ticks from a cycle divider
    if (!s_q.en) begin
      s_d.cyc = '0;
      s_d.ms = '0;
      s_d.acc = '0;
    end else begin
      s_d.cyc = ms_tick ? 16'h0000 : s_q.cyc + 16'h0001;
      if (ms_tick) begin
        s_d.ms = s_q.ms + 4'h1;
      end
      if (win_end) begin
        s_d.ms = '0;
        s_d.acc = '0;
        s_d.var_data = sum_sat;
        s_d.win_cnt = s_q.win_cnt + 16'h0001;
      end else begin
        s_d.acc = acc_nx;
      end
    end

    // register read decode, unmapped words read zero
    case (wb_adr_in & ~8'h03)
      REG_PHY_STS: begin
        rd[PHY_LINK_BIT] = link_valid_in;
        rd[PHY_SPD_BIT] = speed_100_in;
        rd[PHY_POL_BIT] = s_q.pol;
        rd[PHY_MDIX_BIT] = s_q.mdix;
      end
      REG_TEN_SC: begin
        rd[TEN_POL_BIT] = s_q.pol;
      end
      REG_FREQ: begin
        rd[7:0] = s_q.foff;
        rd[FREQ_CTL_LSB +: 8] = s_q.fctl;
      end
      REG_LEN: begin
        rd[7:0] = s_q.len;
      end
      REG_VAR_CTRL: begin
        rd[VC_EN_BIT] = s_q.en;
        rd[VC_TSEL_LSB +: 2] = s_q.tsel;
      end
      REG_VAR_DATA: begin
        rd = s_q.var_data;
      end
      REG_VAR_CNT: begin
        rd[15:0] = s_q.win_cnt;
      end
      default: begin
        rd = WORD_ZERO;
      end
    endcase

    // one wait state: ack rises the cycle after the request, then drops
    s_d.ack = wb_req & ~s_q.ack;
    if (wb_req & ~s_q.ack) begin
      s_d.rdat = rd;
    end
    // write lands on the edge at which the master sees ack
    if (wb_req & s_q.ack & wb_we_in & wb_sel_in[0] & ((wb_adr_in & ~8'h03) == REG_VAR_CTRL)) begin
      s_d.en = wb_dat_in[VC_EN_BIT];
      s_d.tsel = wb_dat_in[VC_TSEL_LSB +: 2];
      // a shorter window picked mid run would leave ms past its end, so restart
      s_d.cyc = '0;
      s_d.ms = '0;
      s_d.acc = '0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_out = s_q.rdat;
  assign wb_ack_out = s_q.ack;
  assign rx_data_out = s_q.rx;
  assign mdix_out = s_q.mdix;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_pol_set: assert property (
    neg_link_pulse_in && !speed_100_in |=> s_q.pol
  ) else $error("polarity flag not set by negative pulse");

  a_pol_fast: assert property (
    speed_100_in |=> !s_q.pol
  ) else $error("polarity flag set at 100Mb");

  a_rx_fix: assert property (
    $past(resetn_in) |-> rx_data_out == ($past(rx_data_in) ^ $past(s_q.pol))
  ) else $error("receive data not corrected for polarity");

  a_mdix_res: assert property (
    autoneg_active_in |=> mdix_out == $past(auto_mdix_en_in && pair_swap_in)
  ) else $error("crossover state not resolved");

  a_freq_gate: assert property (
    !lnk100 |=> s_q.foff == 8'h00 && s_q.fctl == 8'h00
  ) else $error("frequency reported without 100Mb link");

  a_len_gate: assert property (
    !lnk100 |=> s_q.len == 8'h00
  ) else $error("length reported without 100Mb link");

  a_var_stop: assert property (
    !s_q.en |=> s_q.acc == '0 && s_q.ms == 4'h0
  ) else $error("variance runs while disabled");

  a_var_pub: assert property (
    win_end |=> s_q.var_data == $past(sum_sat) && s_q.acc == '0
  ) else $error("window result not published");

  a_var_hold: assert property (
    !win_end |=> $stable(s_q.var_data)
  ) else $error("variance result changed mid window");

  a_win_bound: assert property (
    s_q.en |-> s_q.ms < win_ms
  ) else $error("window ran past selected length");

  a_ack_pulse: assert property (
    wb_ack_out |=> !wb_ack_out
  ) else $error("ack held more than one cycle");

  a_pol_clear: assert property (
    !speed_100_in && !neg_link_pulse_in && pos_link_pulse_in |=> !s_q.pol
  ) else $error("polarity flag not cleared by positive pulse");

  a_pol_hold: assert property (
    !speed_100_in && !neg_link_pulse_in && !pos_link_pulse_in |=> $stable(s_q.pol)
  ) else $error("polarity flag moved without a pulse");

  a_mdix_hold: assert property (
    !autoneg_active_in |=> $stable(mdix_out)
  ) else $error("crossover changed outside negotiation");

  a_mdi_forced: assert property (
    autoneg_active_in && !auto_mdix_en_in |=> !mdix_out
  ) else $error("crossover chosen with auto crossover off");

  a_freq_cap: assert property (
    lnk100 |=> s_q.foff == $past(freq_offset_in) && s_q.fctl == $past(freq_ctrl_in)
  ) else $error("frequency values not captured");

  a_len_calc: assert property (
    lnk100 && !len_sum[8] |=> s_q.len == $past(len_sum[7:0])
  ) else $error("cable length not taken from the estimate");

  a_len_clamp: assert property (
    lnk100 && len_sum[8] |=> s_q.len == LEN_MAX
  ) else $error("cable length not clamped");

  a_var_idle: assert property (
    !s_q.en |-> !win_end
  ) else $error("window ended while disabled");

  a_cyc_bound: assert property (
    s_q.en |-> s_q.cyc < 16'(MS_CYCLES)
  ) else $error("millisecond divider overran");

  a_ms_step: assert property (
    ms_tick && !win_end && !wb_req |=> s_q.ms == $past(s_q.ms) + 4'h1
  ) else $error("millisecond count did not advance");

  a_cnt_step: assert property (
    win_end |=> s_q.win_cnt == $past(s_q.win_cnt) + 16'h0001
  ) else $error("window count did not advance");

  a_cnt_hold: assert property (
    !win_end |=> $stable(s_q.win_cnt)
  ) else $error("window count moved mid window");

  a_sum_sat: assert property (
    win_end && (|sum3[SUM_W-1:32]) |=> s_q.var_data == VAR_SAT
  ) else $error("variance sum wrapped instead of saturating");

  a_ack_answer: assert property (
    wb_req && !wb_ack_out |=> wb_ack_out
  ) else $error("request not acknowledged");

  a_ack_cause: assert property (
    !wb_req |=> !wb_ack_out
  ) else $error("ack without a request");

  a_rdat_hold: assert property (
    !(wb_req && !wb_ack_out) |=> $stable(wb_dat_out)
  ) else $error("read data moved without a request");

  a_sel_guard: assert property (
    wb_req && wb_ack_out && wb_we_in && !wb_sel_in[0] |=> $stable(s_q.en) && $stable(s_q.tsel)
  ) else $error("control written with byte lane off");

  a_ctrl_en: assert property (
    wb_req && wb_ack_out && wb_we_in && wb_sel_in[0] && ((wb_adr_in & ~8'h03) == REG_VAR_CTRL)
      |=> s_q.en == $past(wb_dat_in[VC_EN_BIT])
  ) else $error("enable write did not land");

  a_ctrl_tsel: assert property (
    wb_req && wb_ack_out && wb_we_in && wb_sel_in[0] && ((wb_adr_in & ~8'h03) == REG_VAR_CTRL)
      |=> s_q.tsel == $past(wb_dat_in[VC_TSEL_LSB +: 2]) && s_q.ms == 4'h0
  ) else $error("window select write did not land");
endmodule
`default_nettype wire

// ---- test/lcsd_partner.sv ----
// link partner model: link pulses, raw rx bits and receiver decisions
`default_nettype none
module lcsd_partner (
  input  wire logic              clk_in,
  input  wire logic              neg_req_in,
  input  wire logic              pos_req_in,
  input  wire logic              sym_on_in,
  input  wire logic signed [7:0] err_in,
  output logic                   neg_pulse_out,
  output logic                   pos_pulse_out,
  output logic                   rx_bit_out,
  output logic                   sym_valid_out,
  output logic [1:0]             sym_level_out,
  output logic signed [7:0]      sym_err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    neg_pulse_out = 1'b0;
    pos_pulse_out = 1'b0;
    rx_bit_out = 1'b0;
    sym_valid_out = 1'b0;
    sym_level_out = 2'h0;
    sym_err_out = 8'sh00;
  end
  always @(posedge clk_in) begin
    neg_pulse_out <= neg_req_in;
    pos_pulse_out <= pos_req_in;
    rx_bit_out <= 1'($urandom);
    sym_valid_out <= sym_on_in;
    // levels walk -1, 0, +1 so every accumulator sees traffic
    sym_level_out <= (sym_level_out == 2'h3) ? 2'h0 : ((sym_level_out == 2'h0) ? 2'h1 : 2'h3);
    // idle error lines keep toggling so a stale value is never trusted
    sym_err_out <= sym_on_in ? err_in : ~sym_err_out;
  end
endmodule
`default_nettype wire

// ---- test/lcsd_top_tb.sv ----
// self-checking bench for the linked cable status block
`default_nettype none
module lcsd_top_tb;
  import lcsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, resetn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, fo = 8'h00, fc = 8'h00, digital_equalizer_coeff = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic ack, rx_o, mdix, lnk = 1'b0, spd = 1'b0, an = 1'b0, amx = 1'b0, swp = 1'b0;
  logic neg_rq = 1'b0, pos_rq = 1'b0, sym_on = 1'b0, npl, ppl, rxb, sv, rx_prev = 1'b0;
  logic [1:0] slv;
  logic [2:0] analog_equalizer_setting = 3'h0;
  logic [3:0] sel = 4'hF, bsel = 4'hF;
  logic pol_m = 1'b0, pol_prev = 1'b0;
  logic signed [7:0] err = 8'sh01, serr;
  logic [31:0] exp_q[$];
  int err_count = 0, checks_done = 0, cyc_n = 0, l, e2;
  always #10 clk_in = ~clk_in;
  lcsd_top #(.MS_CYCLES(4)) lcsd_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rdat),
    .wb_ack_out(ack), .link_valid_in(lnk), .speed_100_in(spd), .neg_link_pulse_in(npl),
    .pos_link_pulse_in(ppl), .rx_data_in(rxb), .rx_data_out(rx_o), .autoneg_active_in(an),
    .auto_mdix_en_in(amx), .pair_swap_in(swp), .mdix_out(mdix), .freq_offset_in(fo), .freq_ctrl_in(fc),
    .analog_equalizer_setting_in(analog_equalizer_setting), .digital_equalizer_coeff_in(digital_equalizer_coeff), .sym_valid_in(sv),
    .sym_level_in(slv), .sym_err_in(serr));
  lcsd_partner lcsd_partner_inst (.clk_in(clk_in), .neg_req_in(neg_rq), .pos_req_in(pos_rq),
    .sym_on_in(sym_on), .err_in(err), .neg_pulse_out(npl), .pos_pulse_out(ppl), .rx_bit_out(rxb),
    .sym_valid_out(sv), .sym_level_out(slv), .sym_err_out(serr));
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= bsel;
    do @(posedge clk_in); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // read results are compared at the ack edge, oldest note first
  always @(posedge clk_in) if (ack === 1'b1 && we === 1'b0) chk(exp_q.pop_front(), rdat);
  // raw bit comes back one cycle later, inverted while the flag is set
  // reference polarity flag kept from the pins: 100Mb clears, negative pulse beats positive
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) pol_m <= 1'b0;
    else if (spd) pol_m <= 1'b0;
    else if (npl) pol_m <= 1'b1;
    else if (ppl) pol_m <= 1'b0;
  end
  always @(negedge clk_in) begin
    if (resetn_in && !spd && lnk) chk({31'h0, rx_prev ^ pol_prev}, {31'h0, rx_o});
    rx_prev = rxb;
    pol_prev = pol_m;
  end
  always @(posedge clk_in) if (++cyc_n == 20000) begin
    err_count++;
    results();
  end
  initial begin
    void'($urandom(37465));
    tick(2);
    resetn_in <= 1'b1;
    rd(REG_VAR_CTRL, 32'h0000_0000);
    bsel = 4'hE;
    bus(1'b1, REG_VAR_CTRL, 32'h0000_0007);
    bsel = 4'hF;
    rd(REG_VAR_CTRL, 32'h0000_0000);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    lnk <= 1'b1;
    neg_rq <= 1'b1;
    tick(1);
    neg_rq <= 1'b0;
    tick(3);
    rd(REG_PHY_STS, 32'h0000_1001);
    rd(REG_TEN_SC, 32'h0000_0010);
    pos_rq <= 1'b1;
    tick(1);
    pos_rq <= 1'b0;
    tick(3);
    rd(REG_TEN_SC, 32'h0000_0000);
    neg_rq <= 1'b1; spd <= 1'b1; an <= 1'b1; amx <= 1'b1; swp <= 1'b1;
    tick(1);
    neg_rq <= 1'b0;
    tick(3);
    an <= 1'b0; swp <= 1'b0;
    tick(3);
    rd(REG_PHY_STS, 32'h0000_4003);
    chk(32'h1, {31'h0, mdix});
    an <= 1'b1; amx <= 1'b0; swp <= 1'b1;
    tick(3);
    rd(REG_PHY_STS, 32'h0000_0003);
    for (int i = 0; i < 8; i++) begin
      analog_equalizer_setting <= 3'(i); digital_equalizer_coeff <= 8'($urandom); fo <= 8'($urandom); fc <= 8'($urandom);
      tick(4);
      l = ((int'(LEN_SLOPE[i]) * int'(digital_equalizer_coeff)) >> SLOPE_FRAC) + int'(LEN_OFFSET[i]);
      if (l > 255) l = 255;
      rd(REG_FREQ, {16'h0000, fc, fo});
      rd(REG_LEN, 32'(l));
    end
    lnk <= 1'b0;
    tick(4);
    rd(REG_FREQ, 32'h0000_0000);
    rd(REG_LEN, 32'h0000_0000);
    lnk <= 1'b1;
    sym_on <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, REG_VAR_CTRL, 32'h0000_0000);
      err <= 8'($urandom_range(1, 20));
      tick(2);
      e2 = 8 * (s + 1) * int'(err) * int'(err);
      bus(1'b1, REG_VAR_CTRL, {29'h0, 2'(s), 1'b1});
      rd(REG_VAR_CTRL, {29'h0, 2'(s), 1'b1});
      tick(24 * (s + 1) + 8);
      rd(REG_VAR_DATA, 32'(e2));
    end
    bus(1'b1, REG_VAR_CTRL, 32'h0000_0000);
    err <= 8'sh15;
    tick(80);
    rd(REG_VAR_DATA, 32'(e2));
    tick(2);
    results();
  end
endmodule
`default_nettype wire
